// ### hdl/tac_pkg.sv
// Purpose: Constants and types for the touch converter function control.
// Assumes: 200 MHz system clock, 16-bit register words.
// Notes:   Offsets are page-1 word addresses of the control page.
package tac_pkg;

   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam logic [4:0]  TAC_ADDR_ADC_CTRL = 5'h00;
   localparam logic [4:0]  TAC_ADDR_DAC_PWR  = 5'h02;
   localparam logic [15:0] TAC_ADC_CTRL_RST  = 16'h4000;
   localparam logic [15:0] TAC_DAC_PWR_RST   = 16'h0000;
   localparam logic [15:0] TAC_RD_UNMAPPED   = 16'hFFFF;

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int TAC_PEN_BIT  = 15;
   localparam int TAC_STS_BIT  = 14;
   localparam int TAC_FN_LSB   = 10;
   localparam int TAC_RES_LSB  = 8;
   localparam int TAC_AVG_LSB  = 6;
   localparam int TAC_CLK_LSB  = 4;
   localparam int TAC_PV_LSB   = 1;
   localparam int TAC_DPD_BIT  = 15;

   // -------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------
   localparam int TAC_SYS_MHZ  = 200;
   localparam int TAC_CONV_BITS_EXTRA = 4;

   // Function codes.
   typedef enum logic [3:0] {
      TAC_FN_NONE  = 4'h0, TAC_FN_XY   = 4'h1, TAC_FN_XYZ  = 4'h2,
      TAC_FN_X     = 4'h3, TAC_FN_Y    = 4'h4, TAC_FN_Z    = 4'h5,
      TAC_FN_BATTERY_RESULT_ONE  = 4'h6, TAC_FN_BATTERY_RESULT_TWO = 4'h7, TAC_FN_AUXILIARY_RESULT_ONE = 4'h8,
      TAC_FN_AUXILIARY_RESULT_TWO  = 4'h9, TAC_FN_TMP1 = 4'hA, TAC_FN_PORT = 4'hB,
      TAC_FN_TMP2  = 4'hC, TAC_FN_DRX  = 4'hD, TAC_FN_DRY  = 4'hE,
      TAC_FN_DRYX  = 4'hF
   } tac_fn_t;

   // Result register slot numbers.
   typedef enum logic [3:0] {
      TAC_CH_X = 4'h0, TAC_CH_Y = 4'h1, TAC_CH_Z1 = 4'h2, TAC_CH_Z2 = 4'h3,
      TAC_CH_B1 = 4'h4, TAC_CH_B2 = 4'h5, TAC_CH_A1 = 4'h6,
      TAC_CH_A2 = 4'h7, TAC_CH_T1 = 4'h8, TAC_CH_T2 = 4'h9
   } tac_ch_t;

   // Register bus request.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } tac_req_t;

   // Analog front-end request.
   typedef struct packed {
      logic        start;
      tac_ch_t     chan;
      logic [1:0]  res;
   } tac_conv_t;

   // Panel driver enables: x plus, x minus, y plus, y minus.
   typedef struct packed {
      logic xp;
      logic xn;
      logic yp;
      logic yn;
   } tac_drv_t;

endpackage

// ### hdl/tac_ctrl.sv
// Purpose: Function control of the shared touch-screen converter.
// Assumes: Register port and analog core run on clock_i.
// Notes:   Pen input is a pin and is synchronised before use.
`timescale 1ns/100ps
module tac_ctrl
   import tac_pkg::*;
#(
   parameter int SETTLE_SCALE = 1
) (
   input  wire logic             clock_i,      // System clock.
   input  wire logic             rstn_i,       // Async reset, low.
   input  wire tac_pkg::tac_req_t req_i,       // Register access.
   output logic [15:0]           rdata_o,      // Read data.
   output logic                  rvalid_o,     // Read data valid.
   input  wire logic             pen_down_i,   // Touch detect pin.
   output tac_pkg::tac_conv_t    conv_o,       // Conversion request.
   input  wire logic             conv_done_i,  // Conversion finished.
   input  wire logic [11:0]      conv_data_i,  // Conversion value.
   output logic                  conv_pwr_o,   // Converter powered.
   output logic                  conv_clk_en_o, // Conversion clock tick.
   output tac_pkg::tac_drv_t     drv_o,        // Panel drivers.
   output logic                  res_we_o,     // Result write strobe.
   output tac_pkg::tac_ch_t      res_sel_o,    // Result register.
   output logic [11:0]           res_data_o,   // Result value.
   output logic                  data_ready_n_o, // Low when data ready.
   output logic                  contrast_pd_o // Contrast DAC down.
);
   import tac_pkg::*;

   // -------------------------------------------------------------------
   // Settle and clock constants
   // -------------------------------------------------------------------
   localparam int SET_US [8] = '{0, 100, 500, 1000, 5000, 10000, 50000,
                                 100000};
   localparam int CLK_DIV [4] = '{25, 50, 100, 200};

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SETTLE = 3'b001,
      ST_START  = 3'b010,
      ST_WAIT   = 3'b011,
      ST_STORE  = 3'b100
   } tac_st_t;

   function automatic tac_ch_t first_ch(input logic [3:0] fn);
      case (fn)
         TAC_FN_Y:    first_ch = TAC_CH_Y;
         TAC_FN_Z:    first_ch = TAC_CH_Z1;
         TAC_FN_BATTERY_RESULT_ONE, TAC_FN_PORT: first_ch = TAC_CH_B1;
         TAC_FN_BATTERY_RESULT_TWO: first_ch = TAC_CH_B2;
         TAC_FN_AUXILIARY_RESULT_ONE: first_ch = TAC_CH_A1;
         TAC_FN_AUXILIARY_RESULT_TWO: first_ch = TAC_CH_A2;
         TAC_FN_TMP1: first_ch = TAC_CH_T1;
         TAC_FN_TMP2: first_ch = TAC_CH_T2;
         default:     first_ch = TAC_CH_X;
      endcase
   endfunction

   // Last channel of a function; 1 marks end of sequence.
   function automatic logic last_ch(input logic [3:0] fn, input tac_ch_t c);
      case (fn)
         TAC_FN_XY:   last_ch = (c == TAC_CH_Y);
         TAC_FN_XYZ,
         TAC_FN_Z:    last_ch = (c == TAC_CH_Z2);
         TAC_FN_PORT: last_ch = (c == TAC_CH_A2);
         default:     last_ch = 1'b1;
      endcase
   endfunction

   function automatic logic [4:0] avg_cnt(input logic [1:0] a);
      case (a)
         2'h1:    avg_cnt = 5'h04;
         2'h2:    avg_cnt = 5'h08;
         2'h3:    avg_cnt = 5'h10;
         default: avg_cnt = 5'h01;
      endcase
   endfunction

   // Only codes below the driver group start a measurement sequence.
   function automatic logic is_conv(input logic [3:0] fn);
      is_conv = (fn != TAC_FN_NONE) && (fn < TAC_FN_DRX);
   endfunction

   // Settle wait in system clocks; the scale shortens it for test runs.
   function automatic logic [31:0] settle_cnt(input logic [2:0] pv);
      settle_cnt = 32'(SET_US[pv] * TAC_SYS_MHZ / SETTLE_SCALE);
   endfunction

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   logic        pen_meta_r, pen_r;
   logic        host_mode_r;
   logic [3:0]  fn_r;
   logic [1:0]  res_r, avg_r, clk_r;
   logic [2:0]  pv_r;
   logic        dpd_r;
   tac_st_t     st_r;
   tac_ch_t     ch_r;
   logic [4:0]  n_r;
   logic [15:0] acc_r;
   logic [31:0] wait_r;
   logic [7:0]  div_r;
   logic        busy;
   logic        wr_adc, wr_dac, stop_wr, new_fn;
   logic [15:0] adc_rd;
   logic        pen_last_r;
   logic        rep_r;
   logic        host_go, touch_go;
   logic [3:0]  go_fn;
   logic [2:0]  go_pv;

   assign wr_adc  = req_i.wr && (req_i.addr == TAC_ADDR_ADC_CTRL);
   assign wr_dac  = req_i.wr && (req_i.addr == TAC_ADDR_DAC_PWR);
   assign stop_wr = wr_adc && req_i.wdata[TAC_STS_BIT];
   assign new_fn  = wr_adc && !req_i.wdata[TAC_STS_BIT];
   assign busy    = (st_r != ST_IDLE);
   assign host_go = new_fn && is_conv(req_i.wdata[TAC_FN_LSB +: 4]);
   // In device mode a fresh touch starts the stored panel function, so
   // the host need not poll; a host write in the same cycle wins.
   assign touch_go = host_mode_r && pen_r && !pen_last_r && !busy
                     && !wr_adc && fn_r >= TAC_FN_XY
                     && fn_r <= TAC_FN_Z;
   assign go_fn   = host_go ? req_i.wdata[TAC_FN_LSB +: 4] : fn_r;
   assign go_pv   = host_go ? req_i.wdata[TAC_PV_LSB +: 3] : pv_r;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pen_meta_r <= 1'b0;
         pen_r      <= 1'b0;
         pen_last_r <= 1'b0;
      end else begin
         pen_meta_r <= pen_down_i;
         pen_r      <= pen_meta_r;
         // The pin idles low, so the zero after reset gives no false edge.
         pen_last_r <= pen_r;
      end
   end

   // Bit 0 is not stored at all, so it can only read zero.
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         host_mode_r <= 1'b0;
         fn_r        <= TAC_FN_NONE;
         res_r       <= 2'h0;
         avg_r       <= 2'h0;
         clk_r       <= 2'h0;
         pv_r        <= 3'h0;
         dpd_r       <= 1'b0;
      end else begin
         if (wr_adc) begin
            host_mode_r <= req_i.wdata[TAC_PEN_BIT];
            fn_r  <= req_i.wdata[TAC_FN_LSB +: 4];
            res_r <= req_i.wdata[TAC_RES_LSB +: 2];
            avg_r <= req_i.wdata[TAC_AVG_LSB +: 2];
            clk_r <= req_i.wdata[TAC_CLK_LSB +: 2];
            pv_r  <= req_i.wdata[TAC_PV_LSB +: 3];
         end
         if (wr_dac) begin
            dpd_r <= req_i.wdata[TAC_DPD_BIT];
         end
      end
   end

   // -------------------------------------------------------------------
   // Conversion clock divider
   // -------------------------------------------------------------------
   // The host must pair 8 MHz with 8-bit and 4 MHz with 10-bit; the
   // divider does not police that pairing.
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_r         <= 8'h00;
         conv_clk_en_o <= 1'b0;
      end else if (div_r == 8'(CLK_DIV[clk_r] - 1)) begin
         div_r         <= 8'h00;
         conv_clk_en_o <= 1'b1;
      end else begin
         div_r         <= div_r + 8'h01;
         conv_clk_en_o <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------------
   // Settling applies to panel channels only; other inputs start at once.
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r   <= ST_IDLE;
         ch_r   <= TAC_CH_X;
         n_r    <= 5'h00;
         acc_r  <= 16'h0000;
         wait_r <= 32'h0;
         rep_r  <= 1'b0;
      end else if (stop_wr) begin
         st_r <= ST_IDLE;
      end else begin
         unique case (st_r)
            ST_IDLE: begin
               rep_r <= 1'b0;
               if (host_go || touch_go) begin
                  ch_r   <= first_ch(go_fn);
                  n_r    <= 5'h00;
                  acc_r  <= 16'h0000;
                  wait_r <= settle_cnt(go_pv);
                  st_r   <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               // A lift between repeated scans ends the scan instead of
               // leaving the converter powered while it waits for a touch.
               if (ch_r <= TAC_CH_Z2 && !pen_r && rep_r) begin
                  st_r <= ST_IDLE;
               end else if (ch_r <= TAC_CH_Z2 && !pen_r) begin
                  wait_r <= wait_r;
               end else if (wait_r == 32'h0 || ch_r > TAC_CH_Z2) begin
                  st_r <= ST_START;
               end else begin
                  wait_r <= wait_r - 32'h1;
               end
            end
            ST_START: begin
               st_r <= ST_WAIT;
            end
            ST_WAIT: begin
               if (conv_done_i) begin
                  acc_r <= acc_r + {4'h0, conv_data_i};
                  n_r   <= n_r + 5'h01;
                  st_r  <= (n_r + 5'h01 == avg_cnt(avg_r)) ? ST_STORE
                                                           : ST_START;
               end
            end
            ST_STORE: begin
               n_r   <= 5'h00;
               acc_r <= 16'h0000;
               if (!last_ch(fn_r, ch_r)) begin
                  ch_r <= tac_ch_t'(ch_r + 4'h1);
                  st_r <= ST_START;
               end else if ((fn_r == TAC_FN_XY || fn_r == TAC_FN_XYZ)
                            && pen_r) begin
                  ch_r <= TAC_CH_X;
                  st_r <= ST_SETTLE;
                  rep_r  <= 1'b1;
                  wait_r <= settle_cnt(pv_r);
               end else begin
                  st_r <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         res_we_o   <= 1'b0;
         res_sel_o  <= TAC_CH_X;
         res_data_o <= 12'h000;
      end else begin
         // Only the averaged total is published.
         res_we_o  <= (st_r == ST_STORE) && !stop_wr;
         res_sel_o <= ch_r;
         unique case (avg_r)
            2'h1:    res_data_o <= acc_r[13:2];
            2'h2:    res_data_o <= acc_r[14:3];
            2'h3:    res_data_o <= acc_r[15:4];
            default: res_data_o <= acc_r[11:0];
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         conv_o         <= '0;
         conv_pwr_o     <= 1'b0;
         drv_o          <= '0;
         data_ready_n_o <= 1'b0;
         contrast_pd_o  <= 1'b0;
      end else begin
         conv_o.start   <= (st_r == ST_START) && !stop_wr;
         conv_o.chan    <= ch_r;
         conv_o.res     <= res_r;
         conv_pwr_o     <= busy && !stop_wr;
         data_ready_n_o <= busy && !stop_wr;
         contrast_pd_o  <= dpd_r;
         unique case (fn_r)
            TAC_FN_DRX:  drv_o <= 4'b1100;
            TAC_FN_DRY:  drv_o <= 4'b0011;
            TAC_FN_DRYX: drv_o <= 4'b0110;
            default:     drv_o <= (busy && ch_r == TAC_CH_X) ? 4'b1100 :
                                  (busy && ch_r == TAC_CH_Y) ? 4'b0011 :
                                  (busy && ch_r <= TAC_CH_Z2) ? 4'b0110 :
                                  4'b0000;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------------
   assign adc_rd = {pen_r, !busy, fn_r, res_r, avg_r, clk_r, pv_r,
                    1'b0};

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o  <= 16'h0000;
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= req_i.rd;
         if (req_i.addr == TAC_ADDR_ADC_CTRL) begin
            rdata_o <= adc_rd;
         end else if (req_i.addr == TAC_ADDR_DAC_PWR) begin
            rdata_o <= {dpd_r, 15'h0000};
         end else begin
            rdata_o <= TAC_RD_UNMAPPED;
         end
      end
   end

endmodule

// ### tb/tac_core_model.sv
// Purpose: Stand-in for the analog converter core.
// Assumes: One start pulse per conversion.
// Notes:   Slow mode stretches each conversion.
`timescale 1ns/100ps
module tac_core_model
   import tac_pkg::*;
(
   input  wire logic               clock_i, // Clock.
   input  wire logic               rstn_i,  // Reset, low.
   input  wire tac_pkg::tac_conv_t conv_i,  // Request.
   input  wire logic               slow_i,  // Long conversions.
   output logic                    done_o,  // Result strobe.
   output logic [11:0]             data_o   // Result value.
);
   int         cnt;
   logic [3:0] ch;
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt    <= 0;
         ch     <= 4'h0;
         done_o <= 1'b0;
         data_o <= 12'h000;
      end else begin
         done_o <= (cnt == 1);
         // Data is only good with the strobe, so it churns otherwise.
         data_o <= (cnt == 1) ? {ch, 8'hA5} : ~data_o;
         if (conv_i.start) begin
            cnt <= slow_i ? 450 : 4;
            ch  <= conv_i.chan;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule

// ### tb/tac_ctrl_props.sv
// Purpose: Port checks for the touch converter function control.
// Assumes: Ports only, one clock domain.
// Notes:   Starts are counted per stored result to police averaging.
`timescale 1ns/100ps
module tac_ctrl_props
   import tac_pkg::*;
(
   input wire logic               clock_i,        // Clock.
   input wire logic               rstn_i,         // Reset, low.
   input wire tac_pkg::tac_req_t  req_i,          // Register access.
   input wire logic [15:0]        rdata_o,        // Read data.
   input wire logic               rvalid_o,       // Read valid.
   input wire tac_pkg::tac_conv_t conv_o,         // Conversion request.
   input wire logic               conv_pwr_o,     // Converter powered.
   input wire tac_pkg::tac_drv_t  drv_o,          // Panel drivers.
   input wire logic               res_we_o,       // Result strobe.
   input wire logic               data_ready_n_o, // High while busy.
   input wire logic               contrast_pd_o   // Contrast down.
);
   logic       ctl_wr;
   logic       stop_w;
   logic [4:0] starts_r;
   logic [4:0] need_r;
   assign ctl_wr = req_i.wr && (req_i.addr == TAC_ADDR_ADC_CTRL);
   assign stop_w = ctl_wr && req_i.wdata[TAC_STS_BIT];
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         starts_r <= 5'h00;
      end else if (stop_w) begin
         starts_r <= 5'h00;
      end else if (res_we_o) begin
         starts_r <= {4'h0, conv_o.start};
      end else begin
         starts_r <= starts_r + {4'h0, conv_o.start};
      end
   end
   // Depth follows the last control write; a stop clears the tally.
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         need_r <= 5'h01;
      end else if (ctl_wr) begin
         need_r <= (req_i.wdata[7:6] == 2'b00) ? 5'h01 :
                   5'h02 << req_i.wdata[7:6];
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   sequence s_quiet;
      (!conv_o.start && !res_we_o) [*8];
   endsequence
   a_read_answer: assert property (req_i.rd |=> rvalid_o)
      else $error("read answer missing");
   a_bit0_zero: assert property (req_i.rd && !req_i.addr |=> !rdata_o[0])
      else $error("bit 0 not zero");
   a_contrast_follow: assert property (req_i.wr && req_i.addr ==
      TAC_ADDR_DAC_PWR |-> ##2 contrast_pd_o == $past(req_i.wdata[15], 2))
      else $error("contrast power bit wrong");
   a_status_ready: assert property (req_i.rd && !req_i.addr |=>
      rdata_o[14] != data_ready_n_o) else $error("status bit disagrees");
   a_start_busy: assert property (conv_o.start |->
      conv_pwr_o && data_ready_n_o) else $error("start while idle");
   a_store_busy: assert property (res_we_o |-> data_ready_n_o)
      else $error("result after ready");
   a_avg_count: assert property (res_we_o |-> starts_r == need_r)
      else $error("wrong conversion count");
   a_stop_halts: assert property (stop_w |-> ##[1:3] !conv_pwr_o)
      else $error("stop did not power down");
   a_none_quiet: assert property (ctl_wr && !data_ready_n_o &&
      req_i.wdata[13:10] == 4'h0 |-> ##1 s_quiet)
      else $error("function zero converted");
   a_driver_pairs: assert property (drv_o inside
      {4'h0, 4'hC, 4'h3, 4'h6}) else $error("bad driver pair");
endmodule
bind tac_ctrl tac_ctrl_props tac_ctrl_props_inst (.clock_i(clock_i),
   .rstn_i(rstn_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
   .conv_o(conv_o), .conv_pwr_o(conv_pwr_o), .drv_o(drv_o),
   .res_we_o(res_we_o), .data_ready_n_o(data_ready_n_o),
   .contrast_pd_o(contrast_pd_o));

// ### tb/tac_ctrl_tb.sv
// Purpose: Self-checking bench for the touch converter function control.
// Assumes: Settle counts scaled down by 1000.
// Notes:   Inputs change on the falling edge only.
`timescale 1ns/100ps
`define CHK(a, e) \
   begin \
      cmp_count++; \
      if ((a) !== (e)) begin \
         bad_count++; \
         $display("FAIL %0t got %h exp %h", $time, (a), (e)); \
      end \
   end
module tac_ctrl_tb;
   import tac_pkg::*;
   logic        clock_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        pen = 1'b0;
   logic        slow = 1'b0;
   tac_req_t    req = '0;
   logic        rvalid_o, cdone, pwr, clk_en, we, dav_n, cpd;
   logic [15:0] rdata_o, d, w;
   logic [11:0] cdata, res_d;
   tac_conv_t   conv_o;
   tac_drv_t    drv_o;
   tac_ch_t     sel;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          n;
   int          pf[5] = '{3, 4, 5, 2, 1};
   int          p0[5] = '{0, 1, 2, 0, 0};
   int          ps[5] = '{1, 1, 2, 4, 2};
   int          pn[5] = '{1, 1, 2, 6, 5};
   always #2.5 clock_i = ~clock_i;
   tac_ctrl #(.SETTLE_SCALE(1000)) tac_ctrl_inst (.clock_i(clock_i),
      .rstn_i(rstn_i), .req_i(req), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .pen_down_i(pen), .conv_o(conv_o), .conv_done_i(cdone),
      .conv_data_i(cdata), .conv_pwr_o(pwr), .conv_clk_en_o(clk_en),
      .drv_o(drv_o), .res_we_o(we), .res_sel_o(sel), .res_data_o(res_d),
      .data_ready_n_o(dav_n), .contrast_pd_o(cpd));
   tac_core_model tac_core_model_inst (.clock_i(clock_i), .rstn_i(rstn_i),
      .conv_i(conv_o), .slow_i(slow), .done_o(cdone), .data_o(cdata));
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(negedge clock_i);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(negedge clock_i);
      req.wr = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] v);
      @(negedge clock_i);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(negedge clock_i);
      req.rd = 1'b0;
      v = rdata_o;
   endtask
   task automatic wait_we(input tac_ch_t ch);
      n = 0;
      while (we !== 1'b1 && n < 3000) begin
         @(negedge clock_i);
         n++;
      end
      `CHK(we, 1'b1)
      `CHK(sel, ch)
      `CHK(res_d, {ch, 8'hA5})
      @(negedge clock_i);
   endtask
   task automatic wait_idle();
      n = 0;
      while (dav_n !== 1'b0 && n < 3000) begin
         @(negedge clock_i);
         n++;
      end
      `CHK(dav_n, 1'b0)
   endtask
   task automatic wrap_up();
      $display("Compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #400000;
      bad_count++;
      wrap_up();
   end
   initial begin
      repeat (5) @(negedge clock_i);
      rstn_i = 1'b1;
      rd(TAC_ADDR_ADC_CTRL, d);
      `CHK(d, 16'h4000)
      rd(5'h03, d);
      `CHK(d, 16'hFFFF)
      wr(TAC_ADDR_DAC_PWR, 16'h8000);
      rd(TAC_ADDR_DAC_PWR, d);
      `CHK({cpd, d}, {1'b1, 16'h8000})
      wr(TAC_ADDR_DAC_PWR, 16'h0000);
      @(negedge clock_i);
      `CHK(cpd, 1'b0)
      for (int i = 0; i < 4; i++) begin
         // Resolution tracks the clock so 8 and 4 MHz stay legal.
         w = {2'b01, 4'h0, 2'(i + 1), 2'(i), 2'(i), 3'(i * 3), 1'b1};
         wr(TAC_ADDR_ADC_CTRL, w);
         rd(TAC_ADDR_ADC_CTRL, d);
         `CHK(d, {2'b01, w[13:1], 1'b0})
      end
      wr(TAC_ADDR_ADC_CTRL, 16'h0000);
      repeat (10) @(negedge clock_i);
      `CHK(dav_n, 1'b0)
      for (int f = 6; f <= 12; f++) begin
         wr(TAC_ADDR_ADC_CTRL, {2'b00, 4'(f), 10'h030});
         for (int c = 4; c <= 7 && f == 11; c++) begin
            wait_we(tac_ch_t'(c));
         end
         if (f != 11) begin
            wait_we(tac_ch_t'((f == 12) ? 9 : f - 2));
         end
         wait_idle();
      end
      wr(TAC_ADDR_ADC_CTRL, {2'b00, 4'h6, 10'h0F0});
      repeat (4) @(negedge clock_i);
      `CHK(dav_n, 1'b1)
      wait_we(TAC_CH_B1);
      wait_idle();
      rd(TAC_ADDR_ADC_CTRL, d);
      `CHK(d[14], 1'b1)
      for (int i = 0; i < 5; i++) begin
         pen = 1'b1;
         repeat (4) @(negedge clock_i);
         wr(TAC_ADDR_ADC_CTRL, {2'b00, 4'(pf[i]), 10'h030});
         for (int k = 0; k < pn[i]; k++) begin
            wait_we(tac_ch_t'(p0[i] + k % ps[i]));
         end
         pen = 1'b0;
         wait_idle();
      end
      wr(TAC_ADDR_ADC_CTRL, {2'b10, 4'h3, 10'h030});
      pen = 1'b1;
      wait_we(TAC_CH_X);
      rd(TAC_ADDR_ADC_CTRL, d);
      `CHK(d[15:14], 2'b11)
      pen = 1'b0;
      repeat (4) @(negedge clock_i);
      pen = 1'b1;
      wait_we(TAC_CH_X);
      wait_idle();
      pen = 1'b1;
      repeat (4) @(negedge clock_i);
      wr(TAC_ADDR_ADC_CTRL, {2'b00, 4'h1, 10'h030});
      wait_we(TAC_CH_X);
      wr(TAC_ADDR_ADC_CTRL, {2'b01, 4'h1, 10'h030});
      repeat (3) @(negedge clock_i);
      `CHK(pwr, 1'b0)
      wait_idle();
      for (int p = 0; p < 2; p++) begin
         wr(TAC_ADDR_ADC_CTRL, {2'b00, 4'h3, 6'h03, 3'(p), 1'b0});
         n = 0;
         while (conv_o.start !== 1'b1 && n < 100) begin
            @(negedge clock_i);
            n++;
         end
         `CHK(n >= 20 * p && n <= 20 * p + 6, 1'b1)
         wait_idle();
      end
      for (int f = 13; f <= 15; f++) begin
         wr(TAC_ADDR_ADC_CTRL, {2'b00, 4'(f), 10'h030});
         @(negedge clock_i);
         `CHK(drv_o, (f == 13) ? 4'hC : (f == 14) ? 4'h3 : 4'h6)
      end
      wr(TAC_ADDR_ADC_CTRL, 16'h4000);
      @(negedge clock_i);
      `CHK(drv_o, 4'h0)
      pen = 1'b0;
      slow = 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(TAC_ADDR_ADC_CTRL, {6'h06, 2'(c + 1), 2'b00, 2'(c), 4'h0});
         n = 0;
         while (clk_en !== 1'b1 && n < 300) begin
            @(negedge clock_i);
            n++;
         end
         @(negedge clock_i);
         n = 1;
         while (clk_en !== 1'b1 && n < 300) begin
            @(negedge clock_i);
            n++;
         end
         `CHK(n, 25 << c)
         `CHK(conv_o.res, 2'(c + 1))
         `CHK(conv_o.chan, TAC_CH_B1)
         wr(TAC_ADDR_ADC_CTRL, 16'h4000);
         wait_idle();
      end
      wrap_up();
   end
endmodule
